/* smcc_clock_control.v */
// smcc_clock_control.v: bus clock enables, slow mode, misc control register,
// external interrupt option control, reset pin and mode-select pin logic
// assumes clk_sys is the oscillator, pins sampled synchronously to it
`timescale 1ns/10ps
`default_nettype none
`include "smcc_map.vh"

module smcc_clock_control
#(
  parameter [1:0] BASE_RATIO = `SMCC_RATIO_2
)
(
  input  wire                    clk_sys,
  input  wire                    rst_n,
  input  wire                    porFlag,
  input  wire                    stopEnter,
  input  wire                    cpuIntMask,
  input  wire                    internalReset,
  input  wire                    extIntPending,
  input  wire                    resetPinIn,
  input  wire                    modeSelectPinIn,
  input  wire [`SMCC_ADDR_W-1:0] regAddr,
  input  wire [7:0]              regWrData,
  input  wire                    regWr,
  input  wire                    regRd,
  output reg  [7:0]              regRdData,
  output wire                    busClkEn,
  output wire                    busCtlClkEn,
  output reg                     slowActive,
  output wire                    extIntRisingOption,
  output wire                    extIntFallingOption,
  output wire                    extIntAllow,
  output reg                     extIntClearPending,
  output wire                    resetPinOut,
  output wire                    resetPinOe,
  output wire                    modeSelectPullDown,
  output reg                     nonSingleChip
);

  // misc control register fields and divider state
  reg        slowSelect_q;
  reg        slowSelect_d;
  reg  [1:0] intOpt_q;
  reg  [1:0] intOpt_d;
  reg        intAllow_q;
  reg        intAllow_d;
  reg        slowFallA_q;
  reg        slowFallB_q;
  reg        watchdogCtl_q;
  reg  [7:0] baseCnt_q;
  reg  [3:0] slowCnt_q;
  reg        busCtlTgl_q;
  reg        pullDown_q;
  reg        rstPinLow_q;
  wire       miscHit;
  wire       baseTick;
  wire [7:0] baseLast;
  wire       optChange;
  wire       slowWrap;
  wire       slowSwitch;
  wire [7:0] miscWord;

  // last count of the base predivider for a ratio code
  function [7:0] ratio_last;
    input [1:0] code;
    begin
      case (code)
        `SMCC_RATIO_2:  ratio_last = `SMCC_LAST_2;
        `SMCC_RATIO_4:  ratio_last = `SMCC_LAST_4;
        `SMCC_RATIO_8:  ratio_last = `SMCC_LAST_8;
        default:        ratio_last = `SMCC_LAST_10;
      endcase
    end
  endfunction

  // register select decode
  function is_misc;
    input [`SMCC_ADDR_W-1:0] addr;
    begin
      if (addr == `SMCC_MISC_OFS)
      begin
        is_misc = 1'b1;
      end
      else
      begin
        is_misc = 1'b0;
      end
    end
  endfunction

  // packs the register fields into the read byte
  function [7:0] misc_word;
    input       por;
    input [1:0] opt;
    input       allow;
    input       fallA;
    input       fallB;
    input       slow;
    input       watchdog;
    begin
      misc_word = {por, opt, allow, fallA, fallB, slow, watchdog};
    end
  endfunction

  assign miscHit   = is_misc(regAddr);
  assign optChange = (intOpt_d != intOpt_q);
  assign miscWord  = misc_word(porFlag, intOpt_q, intAllow_q, slowFallA_q,
                               slowFallB_q, slowSelect_q, watchdogCtl_q);
  assign baseLast = ratio_last(BASE_RATIO);
  assign baseTick = (baseCnt_q == baseLast);

  // fixed base predivider
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      baseCnt_q <= 8'h00;
    end
    else if (baseTick)
    begin
      baseCnt_q <= 8'h00;
    end
    else
    begin
      baseCnt_q <= baseCnt_q + 8'h01;
    end
  end

  // divide-by-16 stage counts base ticks only while slow is in effect
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      slowCnt_q <= 4'h0;
    end
    else if (baseTick && slowActive)
    begin
      slowCnt_q <= slowCnt_q + 4'h1;
    end
    else if (baseTick)
    begin
      slowCnt_q <= 4'h0;
    end
  end

  // slow mode taken up or dropped only at a bus period end
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      slowActive <= 1'b0;
    end
    else if (slowSwitch)
    begin
      slowActive <= slowSelect_q;
    end
  end

  assign slowWrap   = ({1'b0, slowCnt_q} == (`SMCC_SLOW_DIV - 5'h01));
  assign slowSwitch = baseTick && (!slowActive || slowWrap);
  assign busClkEn = slowSwitch;

  // bus controller module clock, independent of slow mode
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      busCtlTgl_q <= 1'b0;
    end
    else
    begin
      busCtlTgl_q <= ~busCtlTgl_q;
    end
  end

  assign busCtlClkEn = busCtlTgl_q;

  // slow select next value; stop entry overrides a write
  always @*
  begin
    slowSelect_d = slowSelect_q;
    if (stopEnter)
    begin
      slowSelect_d = 1'b0;
    end
    else if (regWr && miscHit)
    begin
      slowSelect_d = regWrData[`SMCC_BIT_SLOW];
    end
  end

  // trigger options accepted only with the interrupt mask set
  always @*
  begin
    intOpt_d = intOpt_q;
    if (regWr && miscHit && cpuIntMask)
    begin
      intOpt_d = {regWrData[`SMCC_BIT_RISE_OPT],
                  regWrData[`SMCC_BIT_FALL_OPT]};
    end
  end

  // allow bit, written with every register write
  always @*
  begin
    intAllow_d = intAllow_q;
    if (regWr && miscHit)
    begin
      intAllow_d = regWrData[`SMCC_BIT_ALLOW];
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n || porFlag)
    begin
      slowSelect_q <= 1'b0;
      intOpt_q     <= `SMCC_INTOPT_RST;
      intAllow_q   <= `SMCC_ALLOW_RST;
    end
    else
    begin
      slowSelect_q <= slowSelect_d;
      intOpt_q     <= intOpt_d;
      intAllow_q   <= intAllow_d;
    end
  end

  // pending clear pulse one cycle after an option change
  always @(posedge clk_sys)
  begin
    if (!rst_n || porFlag)
    begin
      extIntClearPending <= 1'b0;
    end
    else
    begin
      extIntClearPending <= optChange && extIntPending;
    end
  end

  // plain storage bits, written whole with the register
  always @(posedge clk_sys)
  begin
    if (!rst_n || porFlag)
    begin
      slowFallA_q   <= 1'b0;
      slowFallB_q   <= 1'b0;
      watchdogCtl_q <= 1'b0;
    end
    else if (regWr && miscHit)
    begin
      slowFallA_q   <= regWrData[`SMCC_BIT_FALL_A];
      slowFallB_q   <= regWrData[`SMCC_BIT_FALL_B];
      watchdogCtl_q <= regWrData[`SMCC_BIT_WD_CTL];
    end
  end

  assign extIntRisingOption  = intOpt_q[1];
  assign extIntFallingOption = intOpt_q[0];
  assign extIntAllow         = intAllow_q;

  // read port, data one cycle after the strobe
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      regRdData <= 8'h00;
    end
    else if (regRd && miscHit)
    begin
      regRdData <= miscWord;
    end
    else
    begin
      regRdData <= 8'h00;
    end
  end

  // reset pin open drain drive on internal reset
  always @(posedge clk_sys)
  begin
    if (internalReset)
    begin
      rstPinLow_q <= 1'b1;
    end
    else
    begin
      rstPinLow_q <= 1'b0;
    end
  end

  assign resetPinOut = 1'b0;
  assign resetPinOe  = rstPinLow_q;

  // mode pin pull-down and mode capture at reset release
  always @(posedge clk_sys)
  begin
    if (!resetPinIn || !rst_n)
    begin
      pullDown_q <= 1'b1;
    end
    else if (modeSelectPinIn)
    begin
      pullDown_q <= 1'b0;
    end
  end

  assign modeSelectPullDown = pullDown_q;

  // operating mode latched while reset is held
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      nonSingleChip <= modeSelectPinIn;
    end
  end

endmodule

`default_nettype wire

/* smcc_map.vh */
// smcc_map.vh: register offset, bit positions, reset values and ratio codes
// for the slow mode clock and miscellaneous control block
// assumes inclusion by the single design file
`ifndef SMCC_MAP_VH
`define SMCC_MAP_VH

`define SMCC_ADDR_W         8
`define SMCC_MISC_OFS       8'h0c
`define SMCC_BIT_WD_CTL     0
`define SMCC_BIT_SLOW       1
`define SMCC_BIT_FALL_B     2
`define SMCC_BIT_FALL_A     3
`define SMCC_BIT_ALLOW      4
`define SMCC_BIT_FALL_OPT   5
`define SMCC_BIT_RISE_OPT   6
`define SMCC_BIT_POR        7
`define SMCC_INTOPT_RST     2'h0
`define SMCC_ALLOW_RST      1'h1
`define SMCC_LAST_2         8'h01
`define SMCC_LAST_4         8'h03
`define SMCC_LAST_8         8'h07
`define SMCC_LAST_10        8'h09
`define SMCC_SLOW_DIV       5'h10
`define SMCC_BUSCTL_DIV     4'h2
`define SMCC_RATIO_2        2'h0
`define SMCC_RATIO_4        2'h1
`define SMCC_RATIO_8        2'h2
`define SMCC_RATIO_10       2'h3

`endif

/* smcc_sva.sv */
// smcc_sva.sv: assertions on smcc_clock_control ports
// assumes one clock domain, clk_sys, with sync reset rst_n
`timescale 1ns/10ps
`default_nettype none
module smcc_sva
#(
  parameter [1:0] BASE_RATIO = 2'h0
)
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       cpuIntMask,
  input wire logic       internalReset,
  input wire logic       extIntPending,
  input wire logic       modeSelectPinIn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  input wire logic       busClkEn,
  input wire logic       busCtlClkEn,
  input wire logic       slowActive,
  input wire logic       extIntRisingOption,
  input wire logic       extIntFallingOption,
  input wire logic       extIntAllow,
  input wire logic       extIntClearPending,
  input wire logic       resetPinOut,
  input wire logic       resetPinOe,
  input wire logic       modeSelectPullDown
);
  localparam int R = BASE_RATIO == 2'h0 ? 2 : BASE_RATIO == 2'h1 ? 4 :
                     BASE_RATIO == 2'h2 ? 8 : 10;
  logic [7:0] gap_q;
  logic       seen_q;
  logic       chg_q;
  logic       slowP_q;
  wire  [1:0] opt = {extIntRisingOption, extIntFallingOption};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // cycles since the last bus tick, and whether slow changed meanwhile
  always_ff @(posedge clk_sys)
  begin
    gap_q   <= busClkEn ? 8'h00 : gap_q + 8'h01;
    seen_q  <= rst_n & (seen_q | busClkEn);
    slowP_q <= slowActive;
    chg_q   <= !busClkEn & (chg_q | (slowActive != slowP_q));
  end
  sequence optWr;
    regWr && regAddr == 8'h0c && cpuIntMask;
  endsequence
  bus_ratio_a: assert property (
    busClkEn && seen_q && !chg_q && slowActive == slowP_q
    |-> gap_q == 8'(slowActive ? 16*R-1 : R-1))
    else $error("bus tick spacing wrong");
  opt_write_a: assert property (
    optWr |=> opt == $past(regWrData[6:5]))
    else $error("option write lost");
  opt_lock_a: assert property (
    regWr && regAddr == 8'h0c && !cpuIntMask |=> $stable(opt))
    else $error("option changed while unmasked");
  allow_bit_a: assert property (regWr && regAddr == 8'h0c
    |=> extIntAllow == $past(regWrData[4])) else $error("allow bit wrong");
  clear_pend_a: assert property (optWr ##0 (extIntPending &&
    regWrData[6:5] != opt) |-> ##[1:2] extIntClearPending)
    else $error("pending not cleared");
  reset_drive_a: assert property (internalReset
    |=> resetPinOe && !resetPinOut) else $error("reset pin not driven");
  pull_hold_a: assert property (
    modeSelectPullDown && !modeSelectPinIn |=> modeSelectPullDown)
    else $error("pull-down dropped early");
  ctl_clock_a: assert property (busCtlClkEn
    |=> !busCtlClkEn ##1 busCtlClkEn) else $error("controller clock wrong");
  read_idle_a: assert property ((!regRd || regAddr != 8'h0c)
    |=> regRdData == 8'h00) else $error("read data not idle");
endmodule
bind smcc_clock_control smcc_sva #(.BASE_RATIO(BASE_RATIO)) i_smcc_sva (.*);
`default_nettype wire

/* test_smcc_clock_control.sv */
// test_smcc_clock_control.sv: self-checking bench, base ratio /10
// assumes the design and smcc_sva.sv are compiled before it
`timescale 1ns/10ps
`default_nettype none
module test_smcc_clock_control;
  logic        clk_sys, rst_n, porFlag, stopEnter, cpuIntMask;
  logic        internalReset, extIntPending, resetPinIn, modeSelectPinIn;
  logic        regWr, regRd;
  logic [7:0]  regAddr, regWrData, rdv;
  logic [31:0] r;
  logic [1:0]  opt;
  wire  [7:0]  regRdData;
  wire         busClkEn, busCtlClkEn, slowActive, extIntRisingOption;
  wire         extIntFallingOption, extIntAllow, extIntClearPending;
  wire         resetPinOut, resetPinOe, modeSelectPullDown, nonSingleChip;
  int          failures, comparisons, cyc, n;
  smcc_clock_control #(.BASE_RATIO(2'h3)) i_smcc_clock_control (.*);
  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] ex(input logic [7:0] d, input logic m);
    return {1'b0, m ? d[6:5] : opt, d[4], 2'b00, d[1], 1'b0};
  endfunction
  task automatic chk(input string s, input logic [7:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic m);
    @(posedge clk_sys);
    regAddr <= 8'h0c;
    regWrData <= d;
    cpuIntMask <= m;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    rdv = regRdData;
  endtask
  task automatic gap;
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(negedge clk_sys);
        n++;
      end
      while (busClkEn !== 1'b1 && n < 400);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    {rst_n, porFlag, stopEnter, internalReset, extIntPending} = 5'h00;
    {resetPinIn, modeSelectPinIn, regWr, regRd, cpuIntMask} = 5'h10;
    {regAddr, regWrData, opt, r} = {18'h0, 32'h3c1d};
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h0c);
    chk("misc", 8'h10, rdv & 8'h7e);
    chk("pull", 8'h01, modeSelectPullDown);
    chk("mode", 8'h00, nonSingleChip);
    gap();
    chk("ratio", 8'd10, n);
    wr(8'h12, 1'b1);
    gap();
    chk("slow", 8'd160, n);
    chk("slowact", 8'h01, slowActive);
    rd(8'h0c);
    chk("sm", 8'h02, rdv & 8'h02);
    @(posedge clk_sys);
    stopEnter <= 1'b1;
    @(posedge clk_sys);
    stopEnter <= 1'b0;
    rd(8'h0c);
    chk("stop", 8'h00, rdv & 8'h02);
    wr(8'h02, 1'b1);
    porFlag <= 1'b1;
    rd(8'h0c);
    chk("por", 8'h90, rdv);
    porFlag <= 1'b0;
    gap();
    chk("ratio", 8'd10, n);
    repeat (60)
    begin
      r = lf(r);
      @(posedge clk_sys);
      extIntPending <= r[9];
      internalReset <= r[10];
      wr(r[7:0], r[8]);
      rd(8'h0c);
      chk("misc", ex(r[7:0], r[8]), rdv & 8'h72);
      opt = r[8] ? r[6:5] : opt;
      rd(r[15:8] | 8'h20);
      chk("unmapped", 8'h00, rdv);
    end
    modeSelectPinIn <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("mode", 8'h01, nonSingleChip);
    chk("pull", 8'h00, modeSelectPullDown);
    modeSelectPinIn <= 1'b0;
    resetPinIn <= 1'b0;
    @(posedge clk_sys);
    resetPinIn <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("pull", 8'h01, modeSelectPullDown);
    print_verdict();
  end
endmodule
`default_nettype wire
